// >>> hdl/aodi_dac_if.sv
// Pin-level DAC write, load and FIFO flag logic of an analog output timer.
// Assumes all pins synchronous to aclk; output_timebase is a level sampled here.
`timescale 1ns/10ps

module aodi_dac_if
    import aodi_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timing sources
    input wire logic output_timebase,
    input wire logic primary_update,
    input wire logic secondary_update,
    input wire logic buffer_count_tc,
    // FIFO flags, raw pin levels
    input wire logic fifo_empty_flag,
    input wire logic fifo_half_flag,
    input wire logic fifo_full_flag,
    // CPU bus side
    input wire logic cpu_dac_request_n,
    input wire logic [3:0] bus_addr,
    output logic bus_ready_out,
    // DAC side
    output logic [3:0] dac_channel_addr,
    output logic timed_dac_write_n,
    output logic cpu_dac_write_n,
    output logic [1:0] dac_write_strobe_n,
    output logic [1:0] dac_load_strobe_n,
    output logic timed_data_request,
    // FIFO and counter side
    output logic fifo_retransmit_n,
    output logic fifo_fill_request,
    output logic buffer_count_done
);

    logic [31:0] ctrl_q;
    logic [31:0] fifo_cfg_q;
    logic aw_have_q;
    logic w_have_q;
    logic [3:0] aw_addr_q;
    logic aw_bad_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic tb_prev_q;
    logic tick;
    aodi_state_e state_q;
    logic [3:0] wcnt_q;
    logic [4:0] rem_q;
    logic [3:0] addr_q;
    logic treq_q;
    logic empty_prev_q;
    logic hyst_q;
    logic req_cond;
    logic flag_empty;
    logic flag_half;
    logic flag_full;
    logic multi;
    logic [3:0] chcnt;
    logic dual_pkg;
    logic [1:0] upd_mode;
    logic [1:0] ld_src;
    logic [3:0] pwidth;
    logic cpu_req;
    logic [31:0] status;
    logic tmr_wr;
    logic cpu_wr;

    assign multi = ctrl_q[AODI_MULTI_BIT];
    assign chcnt = ctrl_q[AODI_CHCNT_LSB +: 4];
    assign dual_pkg = ctrl_q[AODI_PKG_BIT];
    assign upd_mode = ctrl_q[AODI_UPDMODE_LSB +: 2];
    assign ld_src = ctrl_q[AODI_LDSRC_LSB +: 2];
    assign pwidth = ctrl_q[AODI_PWIDTH_LSB +: 4];
    assign cpu_req = ~cpu_dac_request_n;
    assign tick = output_timebase & ~tb_prev_q;

    // Polarity bit set means flags are active high; default active low
    assign flag_empty = fifo_cfg_q[AODI_FPOL_BIT] ? fifo_empty_flag : ~fifo_empty_flag;
    assign flag_half = fifo_cfg_q[AODI_FPOL_BIT] ? fifo_half_flag : ~fifo_half_flag;
    assign flag_full = fifo_cfg_q[AODI_FPOL_BIT] ? fifo_full_flag : ~fifo_full_flag;

    assign status = {20'h0_0000, addr_q, 2'h0, treq_q, (state_q == AODI_CPULSE ||
                     state_q == AODI_CDONE), (rem_q != 5'h00), flag_full, flag_half,
                     flag_empty};

    // AXI write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            aw_bad_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AODI_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_have_q & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready <= ~w_have_q & ~s_axi_wready & ~s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr[3:0];
                // Master may move awaddr once taken, so judge it here
                aw_bad_q <= (s_axi_awaddr[31:4] != 28'h000_0000);
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_have_q && w_have_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (!aw_bad_q &&
                    (aw_addr_q == AODI_CTRL_OFS || aw_addr_q == AODI_FIFO_OFS)) ?
                    AODI_RESP_OKAY : AODI_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
        end
    end

    // Register storage, byte lanes honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= AODI_CTRL_RST;
            fifo_cfg_q <= AODI_FIFO_RST;
        end else if (aw_have_q && w_have_q && !s_axi_bvalid && !aw_bad_q) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb_q[b] && aw_addr_q == AODI_CTRL_OFS) begin
                    ctrl_q[b*8 +: 8] <= w_data_q[b*8 +: 8] & AODI_CTRL_MASK[b*8 +: 8];
                end
                if (w_strb_q[b] && aw_addr_q == AODI_FIFO_OFS) begin
                    fifo_cfg_q[b*8 +: 8] <= w_data_q[b*8 +: 8] & AODI_FIFO_MASK[b*8 +: 8];
                end
            end
        end
    end

    // AXI read channel; unmapped offsets answer SLVERR with zero data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AODI_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= AODI_RESP_OKAY;
                if (s_axi_araddr[31:4] != 28'h000_0000) begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= AODI_RESP_SLVERR;
                end else if (s_axi_araddr[3:0] == AODI_CTRL_OFS) begin
                    s_axi_rdata <= ctrl_q;
                end else if (s_axi_araddr[3:0] == AODI_FIFO_OFS) begin
                    s_axi_rdata <= fifo_cfg_q;
                end else if (s_axi_araddr[3:0] == AODI_STAT_OFS) begin
                    s_axi_rdata <= status;
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= AODI_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Timebase edge detector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tb_prev_q <= 1'b0;
        end else begin
            tb_prev_q <= output_timebase;
        end
    end

    // Write sequencer: timed bursts after updates taken outside a burst or CPU pulse, CPU writes in between
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= AODI_IDLE;
            wcnt_q <= 4'h0;
            rem_q <= 5'h00;
            addr_q <= 4'h0;
        end else begin
            // Update arriving mid-burst is dropped; the burst owns the channel
            if (primary_update && rem_q == 5'h00 && state_q != AODI_CPULSE) begin
                rem_q <= multi ? {1'b0, chcnt} + 5'h01 : 5'h01;
                addr_q <= 4'h0;
            end
            unique case (state_q)
                AODI_IDLE: begin
                    if (tick && rem_q != 5'h00 && !flag_empty) begin
                        state_q <= AODI_TPULSE;
                        wcnt_q <= pwidth;
                    end else if (tick && rem_q == 5'h00 && cpu_req) begin
                        state_q <= AODI_CPULSE;
                        wcnt_q <= pwidth;
                        addr_q <= bus_addr;
                    end
                end
                AODI_TPULSE: begin
                    if (tick) begin
                        if (wcnt_q == 4'h0) begin
                            state_q <= AODI_TGAP;
                            rem_q <= rem_q - 5'h01;
                            if (multi) begin
                                addr_q <= addr_q + 4'h1;
                            end
                        end else begin
                            wcnt_q <= wcnt_q - 4'h1;
                        end
                    end
                end
                AODI_TGAP: begin
                    if (tick) begin
                        state_q <= AODI_IDLE;
                    end
                end
                AODI_CPULSE: begin
                    if (tick) begin
                        if (wcnt_q == 4'h0) begin
                            state_q <= AODI_CDONE;
                        end else begin
                            wcnt_q <= wcnt_q - 4'h1;
                        end
                    end
                end
                AODI_CDONE: begin
                    // Hold until the request drops so one request gives one pulse
                    if (!cpu_req) begin
                        state_q <= AODI_IDLE;
                    end
                end
                default: begin
                    state_q <= AODI_IDLE;
                end
            endcase
        end
    end

    assign tmr_wr = (state_q == AODI_TPULSE);
    assign cpu_wr = (state_q == AODI_CPULSE);

    // Write strobes and address pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timed_dac_write_n <= 1'b1;
            cpu_dac_write_n <= 1'b1;
            dac_write_strobe_n <= 2'h3;
            dac_channel_addr <= 4'h0;
        end else begin
            timed_dac_write_n <= ~tmr_wr;
            cpu_dac_write_n <= ~cpu_wr;
            dac_channel_addr <= addr_q;
            if (dual_pkg) begin
                dac_write_strobe_n <= {1'b1, ~(tmr_wr | cpu_wr)};
            end else begin
                dac_write_strobe_n[0] <= ~((tmr_wr | cpu_wr) & ~addr_q[0]);
                dac_write_strobe_n[1] <= ~((tmr_wr | cpu_wr) & addr_q[0]);
            end
        end
    end

    // Load strobes, one per DAC output
    for (genvar i = 0; i < 2; i++) begin : g_load
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                dac_load_strobe_n[i] <= 1'b1;
            end else if (upd_mode[i]) begin
                // Inverse of the merged active-low write lines
                dac_load_strobe_n[i] <= tmr_wr | cpu_wr;
            end else begin
                dac_load_strobe_n[i] <= ~(ld_src[i] ? secondary_update : primary_update);
            end
        end
    end

    // Bus ready handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_ready_out <= 1'b1;
        end else begin
            bus_ready_out <= ~cpu_req | (state_q == AODI_CDONE);
        end
    end

    // Data request while a timed write is starved
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            treq_q <= 1'b0;
        end else if (tick && state_q == AODI_IDLE && rem_q != 5'h00 && flag_empty) begin
            treq_q <= 1'b1;
        end else if (tick && !flag_empty) begin
            treq_q <= 1'b0;
        end
    end

    // Request hysteresis for the half/full mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hyst_q <= 1'b0;
        end else if (flag_full) begin
            hyst_q <= 1'b0;
        end else if (!flag_half) begin
            hyst_q <= 1'b1;
        end
    end

    always_comb begin
        unique case (fifo_cfg_q[AODI_REQSEL_LSB +: 2])
            AODI_REQ_EMPTY: req_cond = flag_empty;
            AODI_REQ_HALF: req_cond = ~flag_half;
            AODI_REQ_NOTFULL: req_cond = ~flag_full;
            AODI_REQ_HYST: req_cond = hyst_q;
        endcase
    end

    // FIFO side pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            empty_prev_q <= 1'b0;
            fifo_retransmit_n <= 1'b1;
            fifo_fill_request <= 1'b0;
            timed_data_request <= 1'b0;
            buffer_count_done <= 1'b0;
        end else begin
            empty_prev_q <= flag_empty;
            fifo_retransmit_n <= ~(fifo_cfg_q[AODI_RTEN_BIT] & flag_empty & ~empty_prev_q);
            fifo_fill_request <= (fifo_cfg_q[AODI_REQEN_BIT] & req_cond) ^
                                 fifo_cfg_q[AODI_REQPOL_BIT];
            timed_data_request <= treq_q;
            buffer_count_done <= ctrl_q[AODI_TCEN_BIT] & buffer_count_tc;
        end
    end

endmodule : aodi_dac_if

// >>> shared/aodi_pkg.sv
// Constants for the analog output DAC pin logic: register map, fields, resets.
// Assumes a single 100 MHz clock and an AXI4-Lite master with 32-bit data.
package aodi_pkg;

    // Register byte offsets
    localparam logic [3:0] AODI_CTRL_OFS = 4'h0;
    localparam logic [3:0] AODI_FIFO_OFS = 4'h4;
    localparam logic [3:0] AODI_STAT_OFS = 4'h8;

    // Control register fields
    localparam int AODI_MULTI_BIT = 0;
    localparam int AODI_CHCNT_LSB = 1;
    localparam int AODI_PKG_BIT = 5;
    localparam int AODI_UPDMODE_LSB = 6;
    localparam int AODI_LDSRC_LSB = 8;
    localparam int AODI_PWIDTH_LSB = 10;
    localparam int AODI_TCEN_BIT = 14;
    localparam logic [31:0] AODI_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] AODI_CTRL_MASK = 32'h0000_7fff;

    // FIFO configuration fields
    localparam int AODI_FPOL_BIT = 0;
    localparam int AODI_RTEN_BIT = 1;
    localparam int AODI_REQEN_BIT = 2;
    localparam int AODI_REQPOL_BIT = 3;
    localparam int AODI_REQSEL_LSB = 4;
    localparam logic [31:0] AODI_FIFO_RST = 32'h0000_0000;
    localparam logic [31:0] AODI_FIFO_MASK = 32'h0000_003f;

    // Status fields
    localparam int AODI_ST_EMPTY_BIT = 0;
    localparam int AODI_ST_HALF_BIT = 1;
    localparam int AODI_ST_FULL_BIT = 2;
    localparam int AODI_ST_TBUSY_BIT = 3;
    localparam int AODI_ST_CBUSY_BIT = 4;
    localparam int AODI_ST_TREQ_BIT = 5;
    localparam int AODI_ST_ADDR_LSB = 8;

    // AXI responses
    localparam logic [1:0] AODI_RESP_OKAY = 2'h0;
    localparam logic [1:0] AODI_RESP_SLVERR = 2'h2;

    // Request condition select codes
    localparam logic [1:0] AODI_REQ_EMPTY = 2'h0;
    localparam logic [1:0] AODI_REQ_HALF = 2'h1;
    localparam logic [1:0] AODI_REQ_NOTFULL = 2'h2;
    localparam logic [1:0] AODI_REQ_HYST = 2'h3;

    // Sequencer states, Gray on every step except the returns to idle
    typedef enum logic [2:0] {
        AODI_IDLE = 3'h0,
        AODI_TPULSE = 3'h1,
        AODI_TGAP = 3'h3,
        AODI_CPULSE = 3'h2,
        AODI_CDONE = 3'h6
    } aodi_state_e;

endpackage : aodi_pkg

// >>> testbench/aodi_dac_if_sva.sv
// Checker for the DAC pin logic, bound to the top module.
// Assumes one aclk domain and synchronous active-low aresetn.
`timescale 1ns/10ps
module aodi_dac_if_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Read channel
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // CPU and DAC pins
    input wire logic cpu_dac_request_n,
    input wire logic bus_ready_out,
    input wire logic [3:0] dac_channel_addr,
    input wire logic timed_dac_write_n,
    input wire logic cpu_dac_write_n,
    input wire logic [1:0] dac_write_strobe_n,
    // FIFO and counter pins
    input wire logic fifo_retransmit_n,
    input wire logic buffer_count_tc,
    input wire logic buffer_count_done
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_ready_drop: assert property ($fell(cpu_dac_request_n) |=> !bus_ready_out)
        else $error("bus ready stayed high after cpu request");
    chk_ready_busy: assert property (!cpu_dac_write_n |-> !bus_ready_out)
        else $error("bus ready high during cpu write");
    chk_ready_back: assert property ($rose(cpu_dac_write_n) |-> ##[0:3] bus_ready_out)
        else $error("bus ready not restored after cpu write");
    chk_strobe_merge: assert property ((dac_write_strobe_n == 2'h3) ==
        (timed_dac_write_n && cpu_dac_write_n))
        else $error("write strobes differ from merged writes");
    chk_one_strobe: assert property (dac_write_strobe_n != 2'h0)
        else $error("both write strobes low");
    chk_no_overlap: assert property (timed_dac_write_n || cpu_dac_write_n)
        else $error("timed and cpu writes overlap");
    chk_addr_hold: assert property ((!timed_dac_write_n && !$past(timed_dac_write_n))
        |-> $stable(dac_channel_addr))
        else $error("channel address moved inside a write pulse");
    chk_retx_single: assert property (!fifo_retransmit_n |=> fifo_retransmit_n)
        else $error("retransmit pulse longer than one cycle");
    chk_tc_cause: assert property (buffer_count_done |-> $past(buffer_count_tc))
        else $error("buffer count done without terminal count");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not returned next cycle");
endmodule : aodi_dac_if_chk

bind aodi_dac_if aodi_dac_if_chk chk_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .cpu_dac_request_n(cpu_dac_request_n), .bus_ready_out(bus_ready_out),
    .dac_channel_addr(dac_channel_addr), .timed_dac_write_n(timed_dac_write_n),
    .cpu_dac_write_n(cpu_dac_write_n), .dac_write_strobe_n(dac_write_strobe_n),
    .fifo_retransmit_n(fifo_retransmit_n), .buffer_count_tc(buffer_count_tc),
    .buffer_count_done(buffer_count_done));

// >>> testbench/aodi_fifo_model.sv
// Output data FIFO flag model seen by the DAC pin logic.
// Assumes the bench sets the fill level; flags are active low unless active_high.
`timescale 1ns/10ps
module aodi_fifo_model (
    // Clock
    input wire logic aclk,
    // Bench control: 0 empty, 1 below half, 2 half or more, 3 full
    input wire logic [1:0] fill_level,
    input wire logic active_high,
    // FIFO pins
    input wire logic fifo_retransmit_n,
    output logic fifo_empty_flag,
    output logic fifo_half_flag,
    output logic fifo_full_flag,
    output int retx_count
);
    assign fifo_empty_flag = (fill_level == 2'h0) ~^ active_high;
    assign fifo_half_flag = (fill_level >= 2'h2) ~^ active_high;
    assign fifo_full_flag = (fill_level == 2'h3) ~^ active_high;
    // Counts low cycles; one per retransmit when pulses are single-cycle
    always @(posedge aclk) begin
        if (fifo_retransmit_n === 1'h0) retx_count <= retx_count + 1;
    end
endmodule : aodi_fifo_model

// >>> testbench/tb_top.sv
// Self-checking bench for the DAC pin logic over AXI4-Lite.
// Assumes a 100 MHz aclk; the timebase ticks every four aclk cycles.
`timescale 1ns/10ps
module tb_top
    import aodi_pkg::*;
;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, bus_addr = 4'h0, dac_channel_addr;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, dac_write_strobe_n, dac_load_strobe_n;
    logic [1:0] fill_level = 2'h3, tb_cnt = 2'h0;
    logic output_timebase = 1'h0, primary_update = 1'h0, secondary_update = 1'h0;
    logic buffer_count_tc = 1'h0, cpu_dac_request_n = 1'h1, active_high = 1'h0;
    logic fifo_empty_flag, fifo_half_flag, fifo_full_flag, bus_ready_out;
    logic timed_dac_write_n, cpu_dac_write_n, timed_data_request, fifo_retransmit_n;
    logic fifo_fill_request, buffer_count_done, prev_tw = 1'h1, prev_cw = 1'h1;
    int num_errors = 0, samples_checked = 0, cpu_pulses = 0, retx_count;
    logic [5:0] evq[$];
    localparam logic [31:0] CTRL = 32'(AODI_CTRL_OFS), FIFO = 32'(AODI_FIFO_OFS);
    localparam logic [31:0] STAT = 32'(AODI_STAT_OFS);

    aodi_dac_if dut_u (.*);
    aodi_fifo_model fifo_u (.aclk(aclk), .fill_level(fill_level), .active_high(active_high),
        .fifo_retransmit_n(fifo_retransmit_n), .fifo_empty_flag(fifo_empty_flag),
        .fifo_half_flag(fifo_half_flag), .fifo_full_flag(fifo_full_flag),
        .retx_count(retx_count));

    always #5 aclk = ~aclk;
    // Timebase, a log of every timed write pulse start and a count of CPU write pulses
    always @(posedge aclk) begin
        tb_cnt <= tb_cnt + 2'h1;
        output_timebase <= tb_cnt[1];
        prev_tw <= timed_dac_write_n;
        prev_cw <= cpu_dac_write_n;
        if (prev_tw && !timed_dac_write_n) evq.push_back({dac_channel_addr, dac_write_strobe_n});
        if (prev_cw && !cpu_dac_write_n) cpu_pulses++;
    end

    task automatic complete_run;
        $display("Errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'h0;
        w = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready === 1'h1) begin
                aw = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w && s_axi_wready === 1'h1) begin
                w = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        s_axi_bready <= 1'h1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        check(32'(s_axi_bresp), 32'(er));
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : axi_rd

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        check(d, ed);
        check(32'(r), 32'(er));
    endtask : rd_chk

    task automatic t_regs;
        rd_chk(CTRL, AODI_CTRL_RST, AODI_RESP_OKAY);
        rd_chk(FIFO, AODI_FIFO_RST, AODI_RESP_OKAY);
        axi_wr(CTRL, 32'hffff_ffff, AODI_RESP_OKAY);
        rd_chk(CTRL, AODI_CTRL_MASK, AODI_RESP_OKAY);
        axi_wr(32'h10, 32'h1, AODI_RESP_SLVERR);
        axi_wr(STAT, 32'h1, AODI_RESP_SLVERR);
        rd_chk(CTRL, AODI_CTRL_MASK, AODI_RESP_OKAY);
        rd_chk(32'h10, 32'h0, AODI_RESP_SLVERR);
        axi_wr(CTRL, 32'h0, AODI_RESP_OKAY);
    endtask : t_regs

    task automatic upd(input int n);
        evq.delete();
        primary_update <= 1'h1;
        tick(1);
        primary_update <= 1'h0;
        tick(n);
    endtask : upd

    // Expected log entries packed six bits each, first channel lowest
    task automatic burst(input logic [31:0] ctrl, input logic [17:0] exp, input int n);
        axi_wr(CTRL, ctrl, AODI_RESP_OKAY);
        upd(200);
        check(32'(evq.size()), 32'(n));
        for (int i = 0; i < n; i++) check(32'(evq[i]), 32'(exp[6*i +: 6]));
    endtask : burst

    task automatic t_empty;
        int c0;
        axi_wr(FIFO, 32'h2, AODI_RESP_OKAY);
        axi_wr(CTRL, 32'h405, AODI_RESP_OKAY);
        c0 = retx_count;
        fill_level <= 2'h0;
        upd(60);
        check(32'(evq.size()), 32'h0);
        check(32'(timed_data_request), 32'h1);
        rd_chk(STAT, 32'h29, AODI_RESP_OKAY);
        check(32'(retx_count), 32'(c0 + 1));
        fill_level <= 2'h2;
        tick(200);
        check(32'(evq.size()), 32'h3);
        check(32'(timed_data_request), 32'h0);
    endtask : t_empty

    task automatic t_req;
        logic [1:0] seq [6] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h2, 2'h3};
        logic h, e;
        logic [31:0] d;
        logic [1:0] r;
        h = 1'h0;
        for (int m = 0; m < 4; m++) begin
            axi_wr(FIFO, 32'(4 + m * 16), AODI_RESP_OKAY);
            for (int i = 0; i < 6; i++) begin
                fill_level <= seq[i];
                tick(4);
                if (seq[i] == 2'h3) h = 1'h0;
                else if (seq[i] <= 2'h1) h = 1'h1;
                e = m == 0 ? seq[i] == 2'h0 : m == 1 ? seq[i] <= 2'h1 : m == 2 ? seq[i] != 2'h3 : h;
                check(32'(fifo_fill_request), 32'(e));
                axi_rd(STAT, d, r);
                check(32'(d[2:0]), 32'({seq[i] == 2'h3, seq[i] >= 2'h2, seq[i] == 2'h0}));
            end
        end
        active_high <= 1'h1;
        axi_wr(FIFO, 32'hd, AODI_RESP_OKAY);
        fill_level <= 2'h0;
        tick(4);
        check(32'(fifo_fill_request), 32'h0);
        rd_chk(STAT, 32'h301, AODI_RESP_OKAY);
        axi_wr(FIFO, 32'h1, AODI_RESP_OKAY);
        tick(4);
        check(32'(fifo_fill_request), 32'h0);
        active_high <= 1'h0;
        fill_level <= 2'h3;
        axi_wr(FIFO, 32'h0, AODI_RESP_OKAY);
    endtask : t_req

    task automatic t_cpu;
        int c0, w;
        c0 = cpu_pulses;
        w = 1;
        axi_wr(CTRL, 32'h8c0, AODI_RESP_OKAY);
        bus_addr <= 4'h5;
        cpu_dac_request_n <= 1'h0;
        tick(2);
        check(32'(bus_ready_out), 32'h0);
        for (int i = 0; i < 100 && cpu_dac_write_n !== 1'h0; i++) tick(1);
        check(32'(dac_channel_addr), 32'h5);
        check(32'(dac_write_strobe_n), 32'h1);
        check(32'(dac_load_strobe_n), 32'h3);
        for (int i = 0; i < 100 && bus_ready_out !== 1'h1; i++) begin
            tick(1);
            if (cpu_dac_write_n === 1'h0) w++;
        end
        check(32'(w), 32'hc);
        cpu_dac_request_n <= 1'h1;
        tick(20);
        check(32'(cpu_pulses - c0), 32'h1);
        check(32'(bus_ready_out), 32'h1);
        check(32'(dac_load_strobe_n), 32'h0);
    endtask : t_cpu

    task automatic t_pins;
        axi_wr(CTRL, 32'h4200, AODI_RESP_OKAY);
        secondary_update <= 1'h1;
        buffer_count_tc <= 1'h1;
        tick(3);
        check(32'(dac_load_strobe_n), 32'h1);
        check(32'(buffer_count_done), 32'h1);
        secondary_update <= 1'h0;
        axi_wr(CTRL, 32'h0, AODI_RESP_OKAY);
        tick(3);
        check(32'(dac_load_strobe_n), 32'h3);
        check(32'(buffer_count_done), 32'h0);
        buffer_count_tc <= 1'h0;
    endtask : t_pins

    initial begin
        tick(8);
        aresetn <= 1'h1;
        tick(2);
        t_regs();
        burst(32'h405, {6'h0a, 6'h05, 6'h02}, 3);
        burst(32'h23, {6'h00, 6'h06, 6'h02}, 2);
        burst(32'h4, {6'h00, 6'h00, 6'h02}, 1);
        t_empty();
        t_req();
        t_cpu();
        t_pins();
        complete_run();
    end

    // Whole run is near 1250 cycles; the limit leaves ample margin
    initial begin
        #100000;
        num_errors++;
        complete_run();
    end
endmodule : tb_top
